// ==== pin_cfg_top.sv ====
// Pin configuration block: AXI4-Lite registers, input conditioning, wake-up and output drive.
// Notes on behaviour
// - Wake-disable bit 0 lets a passive-to-active input transition wake; 1 blocks wake.
// - Input polarity bit 1 means active high, 0 means active low.
// - Pin three function: reserved, input, open-drain output, push-pull output.
// - Pin two function: power-domain enable input, input, open-drain, supply-fault output.
// - Pin four function: system-domain enable input, input, open-drain, push-pull.
// - Wake sensitivity bit 0 selects edge wake, 1 selects level wake.
// - Output with static source drives its mode bit as the pin value.
// - Output with other source uses mode bit as active level, 1 high.
// - Input pin mode bit turns debouncing off with 0, on with 1.
// - Pin two output source: static, fault, slow clock, sequencer.
// - Pin one output source: static, fault, clock, sequencer, input 0, reserved, inputs 2, 3.
// - Pin zero output source: static, fault, clock, sequencer, reserved, inputs 1, 2, 3.
// - Pin three output source: static, fault, clock, sequencer, inputs 0, 1, 2, reserved.
// - Pin four output source: static, fault, slow clock, sequencer.
// - Pin zero function 00 is watchdog trigger input; pin one 00 reserved.
// - Debounce uses shared time field, none to 1024 ms.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pin_cfg_top #(
	parameter int DEB_SCALE = 1
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [4:0]  pin_in,
	output logic [4:0]       pin_out,
	output logic [4:0]       pin_oe,
	input  wire logic        supply_fault_flag,
	input  wire logic        slow_clock_in,
	input  wire logic [4:0]  sequencer_ctrl,
	output logic             wake_request,
	output logic             power_domain_enable,
	output logic             system_domain_enable,
	output logic             watchdog_trigger,
	output logic             irq
);
	localparam int N = pin_cfg_pkg::NUM_PINS;

	logic [7:0] cfg01_reg, cfg01_next, cfg23_reg, cfg23_next, cfg4_reg, cfg4_next;
	logic [7:0] deb_reg, deb_next, wks_reg, wks_next, mode_reg, mode_next;
	logic [7:0] src02_reg, src02_next, src34_reg, src34_next;
	logic [4:0] stat_reg, stat_next, mask_reg, mask_next;
	logic       aw_held_reg, aw_held_next, w_held_reg, w_held_next, bvalid_reg, bvalid_next;
	logic       rvalid_reg, rvalid_next;
	logic [7:0] aw_idx_reg, aw_idx_next;
	logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic [3:0]  wstrb_reg, wstrb_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;

	// Two-flop synchronisers for pins and asynchronous sources.
	logic [4:0] in_s1_reg, in_s2_reg, seq_s1_reg, seq_s2_reg;
	logic       flt_s1_reg, flt_s2_reg, clk_s1_reg, clk_s2_reg;

	pin_cfg_pkg::pin_cfg_t cfg [N];
	logic [4:0] act_raw, act_deb, deb_en, is_input, pin_act_prev_reg, wake_evt;
	logic [4:0] filt_reg, filt_next;
	logic [31:0] deb_cnt_reg [N];
	logic [31:0] deb_cnt_next [N];
	logic [31:0] deb_limit;
	pin_cfg_pkg::pin_drive_t drive_reg, drive_next;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Pins keep sampling in reset, so the filter starts from the true level.
			in_s1_reg  <= pin_in;
			in_s2_reg  <= in_s1_reg;
			seq_s1_reg <= 5'h00;
			seq_s2_reg <= 5'h00;
			flt_s1_reg <= 1'b0;
			flt_s2_reg <= 1'b0;
			clk_s1_reg <= 1'b0;
			clk_s2_reg <= 1'b0;
		end else begin
			in_s1_reg  <= pin_in;
			in_s2_reg  <= in_s1_reg;
			seq_s1_reg <= sequencer_ctrl;
			seq_s2_reg <= seq_s1_reg;
			flt_s1_reg <= supply_fault_flag;
			flt_s2_reg <= flt_s1_reg;
			clk_s1_reg <= slow_clock_in;
			clk_s2_reg <= clk_s1_reg;
		end
	end

	// Per-pin field unpacking; pins 0/1 share one register as do 2/3.
	always_comb begin
		cfg[0] = {cfg01_reg[3], cfg01_reg[2], cfg01_reg[1:0], wks_reg[0], mode_reg[0], src02_reg[2:0]};
		cfg[1] = {cfg01_reg[7], cfg01_reg[6], cfg01_reg[5:4], wks_reg[1], mode_reg[1], src02_reg[5:3]};
		cfg[2] = {cfg23_reg[3], cfg23_reg[2], cfg23_reg[1:0], wks_reg[2], mode_reg[2],
			{1'b0, src02_reg[7:6]}};
		cfg[3] = {cfg23_reg[7], cfg23_reg[6], cfg23_reg[5:4], wks_reg[3], mode_reg[3], src34_reg[2:0]};
		cfg[4] = {cfg4_reg[3], cfg4_reg[2], cfg4_reg[1:0], wks_reg[4], mode_reg[4],
			{1'b0, src34_reg[4:3]}};
	end

	// Debounce length from the shared time field, in cycles rounded up.
	// A 32-bit count covers the longest time at the full clock rate.
	always_comb begin
		deb_limit = 32'((longint'(pin_cfg_pkg::DEB_US[deb_reg[2:0]]) * pin_cfg_pkg::CLK_HZ
			+ pin_cfg_pkg::DEB_DIV_US - 1) / pin_cfg_pkg::DEB_DIV_US / DEB_SCALE);
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_pin
			// Code 00 of pins one and three is reserved and gives no input function.
			assign is_input[g] = !cfg[g].function_sel[1] && !((g == 1 || g == 3)
				&& cfg[g].function_sel == pin_cfg_pkg::FN_SPECIAL_IN);
			assign act_raw[g]  = in_s2_reg[g] ~^ cfg[g].input_polarity;
			assign deb_en[g]   = is_input[g] && cfg[g].mode_bit && (deb_reg[2:0] != 3'h0);
			always_comb begin
				filt_next[g]       = filt_reg[g];
				deb_cnt_next[g]    = 32'h0;
				if (!deb_en[g] || act_raw[g] == filt_reg[g]) begin
					filt_next[g] = act_raw[g];
				end else if (deb_cnt_reg[g] + 32'h1 >= deb_limit) begin
					filt_next[g] = act_raw[g];
				end else begin
					deb_cnt_next[g] = deb_cnt_reg[g] + 32'h1;
				end
			end
			assign act_deb[g] = filt_reg[g];
			// Edge wakes on passive-to-active; level wakes while active.
			assign wake_evt[g] = is_input[g] && !cfg[g].wake_disable && act_deb[g]
				&& (cfg[g].wake_level_sel || !pin_act_prev_reg[g]);
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Loading the live level avoids a false edge wake right after reset.
			filt_reg         <= act_raw;
			pin_act_prev_reg <= act_raw;
			for (int i = 0; i < N; i++) begin
				deb_cnt_reg[i] <= 32'h0;
			end
		end else begin
			filt_reg         <= filt_next;
			pin_act_prev_reg <= act_deb;
			for (int i = 0; i < N; i++) begin
				deb_cnt_reg[i] <= deb_cnt_next[i];
			end
		end
	end

	// Output source selection and drive.
	// Sources are synchronised levels, so the slow clock output is a sampled copy.
	function automatic logic src_level(input logic [2:0] sel, input int pin, input logic mode,
		input logic flt, input logic clk, input logic seq, input logic [4:0] act);
		logic lvl;
		lvl = 1'b0;
		unique case (sel)
			pin_cfg_pkg::SRC_STATIC:    lvl = mode;
			pin_cfg_pkg::SRC_FAULT:     lvl = flt ~^ mode;
			pin_cfg_pkg::SRC_SLOW_CLK:  lvl = clk ~^ mode;
			pin_cfg_pkg::SRC_SEQUENCER: lvl = seq ~^ mode;
			default: begin
				// Forward of input n = sel-4, own index is reserved.
				if (32'(sel) - 32'd4 == 32'(pin)) begin
					lvl = !mode;
				end else begin
					lvl = act[sel[1:0]] ~^ mode;
				end
			end
		endcase
		return lvl;
	endfunction

	always_comb begin
		for (int i = 0; i < N; i++) begin
			drive_next.pin_out[i] = src_level(cfg[i].out_source, i, cfg[i].mode_bit, flt_s2_reg,
				clk_s2_reg, seq_s2_reg[i], act_deb);
			drive_next.pin_oe[i] = 1'b0;
			unique case (cfg[i].function_sel)
				pin_cfg_pkg::FN_PUSH_PULL:  drive_next.pin_oe[i] = 1'b1;
				// Open drain only sinks; high is released to the pull-up.
				pin_cfg_pkg::FN_OPEN_DRAIN: begin
					drive_next.pin_oe[i]  = !drive_next.pin_out[i];
					drive_next.pin_out[i] = 1'b0;
				end
				default: begin
					drive_next.pin_out[i] = 1'b0;
				end
			endcase
		end
		// Pin two code 11 is the fault output, push-pull with the fault source.
		if (cfg[2].function_sel == pin_cfg_pkg::FN_PUSH_PULL) begin
			drive_next.pin_out[2] = flt_s2_reg ~^ cfg[2].mode_bit;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_reg <= '0;
		end else begin
			drive_reg <= drive_next;
		end
	end
	assign pin_out = drive_reg.pin_out;
	assign pin_oe  = drive_reg.pin_oe;

	// Special input functions; pin one code 00 and pin three code 00 do nothing.
	assign power_domain_enable  = (cfg[2].function_sel == pin_cfg_pkg::FN_SPECIAL_IN) && act_deb[2];
	assign system_domain_enable = (cfg[4].function_sel == pin_cfg_pkg::FN_SPECIAL_IN) && act_deb[4];
	assign watchdog_trigger     = (cfg[0].function_sel == pin_cfg_pkg::FN_SPECIAL_IN) && act_deb[0];
	assign wake_request         = |wake_evt;
	assign irq                  = |(stat_reg & mask_reg);

	// AXI4-Lite slave: address and data taken in either order, one write and one read in flight.
	logic       wr_go, rd_go;
	logic [7:0] ar_idx;
	logic [7:0] wb;
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign ar_idx        = s_axi_araddr[9:2];
	assign rd_go         = s_axi_arvalid && s_axi_arready;

	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next  = w_held_reg;
		aw_idx_next  = aw_idx_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg && !s_axi_bready;
		bresp_next   = bresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			aw_idx_next  = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			wdata_next  = s_axi_wdata;
			wstrb_next  = s_axi_wstrb;
		end
		// The write lands one edge after both halves are held, and the response rises on that same edge.
		wr_go = aw_held_reg && w_held_reg;
		wb    = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;
		cfg01_next = cfg01_reg;
		cfg23_next = cfg23_reg;
		cfg4_next  = cfg4_reg;
		deb_next   = deb_reg;
		wks_next   = wks_reg;
		mode_next  = mode_reg;
		src02_next = src02_reg;
		src34_next = src34_reg;
		mask_next  = mask_reg;
		stat_next  = stat_reg;
		if (wr_go) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = pin_cfg_pkg::AXI_OKAY;
			if (wstrb_reg[0]) begin
				// Reserved bits are kept as written, except in the IRQ mask and status, which hold bits 4:0 only.
				unique case (aw_idx_reg)
					pin_cfg_pkg::IDX_PIN01_CFG:  cfg01_next = wb;
					pin_cfg_pkg::IDX_PIN23_CFG:  cfg23_next = wb;
					pin_cfg_pkg::IDX_PIN4_CFG:   cfg4_next  = wb;
					pin_cfg_pkg::IDX_DEBOUNCE:   deb_next   = wb;
					pin_cfg_pkg::IDX_WAKE_SENS:  wks_next   = wb;
					pin_cfg_pkg::IDX_MODE_BITS:  mode_next  = wb;
					pin_cfg_pkg::IDX_OUT_SRC_02: src02_next = wb;
					pin_cfg_pkg::IDX_OUT_SRC_34: src34_next = wb;
					pin_cfg_pkg::IDX_IRQ_MASK:   mask_next  = wb[4:0];
					pin_cfg_pkg::IDX_IRQ_STATUS: stat_next  = stat_reg & ~wb[4:0];
					pin_cfg_pkg::IDX_PIN_STATE:  bresp_next = pin_cfg_pkg::AXI_OKAY;
					default:                     bresp_next = pin_cfg_pkg::AXI_SLVERR;
				endcase
			end
		end
		// A new wake event wins over a clear in the same cycle.
		stat_next = stat_next | wake_evt;
	end

	always_comb begin
		rvalid_next = rvalid_reg && !s_axi_rready;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (rd_go) begin
			rvalid_next = 1'b1;
			rresp_next  = pin_cfg_pkg::AXI_OKAY;
			unique case (ar_idx)
				pin_cfg_pkg::IDX_PIN01_CFG:  rdata_next = {24'h0, cfg01_reg};
				pin_cfg_pkg::IDX_PIN23_CFG:  rdata_next = {24'h0, cfg23_reg};
				pin_cfg_pkg::IDX_PIN4_CFG:   rdata_next = {24'h0, cfg4_reg};
				pin_cfg_pkg::IDX_DEBOUNCE:   rdata_next = {24'h0, deb_reg};
				pin_cfg_pkg::IDX_WAKE_SENS:  rdata_next = {24'h0, wks_reg};
				pin_cfg_pkg::IDX_MODE_BITS:  rdata_next = {24'h0, mode_reg};
				pin_cfg_pkg::IDX_OUT_SRC_02: rdata_next = {24'h0, src02_reg};
				pin_cfg_pkg::IDX_OUT_SRC_34: rdata_next = {24'h0, src34_reg};
				pin_cfg_pkg::IDX_IRQ_STATUS: rdata_next = {27'h0, stat_reg};
				pin_cfg_pkg::IDX_IRQ_MASK:   rdata_next = {27'h0, mask_reg};
				pin_cfg_pkg::IDX_PIN_STATE:  rdata_next = {22'h0, act_deb, in_s2_reg};
				default: begin
					rdata_next = 32'h0;
					rresp_next = pin_cfg_pkg::AXI_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg01_reg   <= pin_cfg_pkg::CFG_RESET;
			cfg23_reg   <= pin_cfg_pkg::CFG_RESET;
			cfg4_reg    <= pin_cfg_pkg::CFG_RESET;
			deb_reg     <= pin_cfg_pkg::CFG_RESET;
			wks_reg     <= pin_cfg_pkg::CFG_RESET;
			mode_reg    <= pin_cfg_pkg::CFG_RESET;
			src02_reg   <= pin_cfg_pkg::CFG_RESET;
			src34_reg   <= pin_cfg_pkg::CFG_RESET;
			stat_reg    <= 5'h00;
			mask_reg    <= 5'h00;
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_idx_reg  <= 8'h00;
			wdata_reg   <= 32'h0;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'h0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= 2'h0;
		end else begin
			cfg01_reg   <= cfg01_next;
			cfg23_reg   <= cfg23_next;
			cfg4_reg    <= cfg4_next;
			deb_reg     <= deb_next;
			wks_reg     <= wks_next;
			mode_reg    <= mode_next;
			src02_reg   <= src02_next;
			src34_reg   <= src34_next;
			stat_reg    <= stat_next;
			mask_reg    <= mask_next;
			aw_held_reg <= aw_held_next;
			w_held_reg  <= w_held_next;
			aw_idx_reg  <= aw_idx_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end
endmodule

// ==== pin_cfg_pkg.sv ====
// Package with register map, field layouts, reset values and timing for the pin configuration block.
package pin_cfg_pkg;
	localparam int NUM_PINS = 5;
	// Printed offsets are not word multiples, so they are register indices.
	localparam logic [7:0] IDX_PIN01_CFG    = 8'h15;
	localparam logic [7:0] IDX_PIN23_CFG    = 8'h16;
	localparam logic [7:0] IDX_PIN4_CFG     = 8'h17;
	localparam logic [7:0] IDX_DEBOUNCE     = 8'h18;
	localparam logic [7:0] IDX_WAKE_SENS    = 8'h1C;
	localparam logic [7:0] IDX_MODE_BITS    = 8'h1D;
	localparam logic [7:0] IDX_OUT_SRC_02   = 8'h1E;
	localparam logic [7:0] IDX_OUT_SRC_34   = 8'h1F;
	localparam logic [7:0] IDX_IRQ_STATUS   = 8'h30;
	localparam logic [7:0] IDX_IRQ_MASK     = 8'h31;
	localparam logic [7:0] IDX_PIN_STATE    = 8'h32;
	localparam logic [7:0] CFG_RESET        = 8'h00;
	localparam logic [1:0] AXI_OKAY         = 2'h0;
	localparam logic [1:0] AXI_SLVERR       = 2'h2;
	// Pin function encodings.
	localparam logic [1:0] FN_SPECIAL_IN    = 2'h0;
	localparam logic [1:0] FN_INPUT         = 2'h1;
	localparam logic [1:0] FN_OPEN_DRAIN    = 2'h2;
	localparam logic [1:0] FN_PUSH_PULL     = 2'h3;
	// Output source encodings.
	localparam logic [2:0] SRC_STATIC       = 3'h0;
	localparam logic [2:0] SRC_FAULT        = 3'h1;
	localparam logic [2:0] SRC_SLOW_CLK     = 3'h2;
	localparam logic [2:0] SRC_SEQUENCER    = 3'h3;
	localparam logic [2:0] SRC_FWD0         = 3'h4;
	// Debounce times in microseconds, index 0 meaning none.
	localparam int CLK_HZ = 40000000;
	localparam int DEB_US [8] = '{0, 100, 1000, 10240, 51200, 256000, 512000, 1024000};
	localparam int DEB_DIV_US = 1000000;
	typedef struct packed {
		logic       wake_disable;
		logic       input_polarity;
		logic [1:0] function_sel;
		logic       wake_level_sel;
		logic       mode_bit;
		logic [2:0] out_source;
	} pin_cfg_t;
	typedef struct packed {
		logic [4:0] pin_out;
		logic [4:0] pin_oe;
	} pin_drive_t;
endpackage

// ==== pin_cfg_props.sv ====
// Checker of bus handshakes and reset state at the ports of the pin configuration block.
`timescale 1ns/1ps
module pin_cfg_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [4:0]  pin_oe,
	input wire logic        irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_reset_quiet: assert property ($rose(aresetn) |->
		pin_oe == 5'h00 && !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not quiet after reset");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read response dropped");
	chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during response");
	chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
	chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == pin_cfg_pkg::AXI_SLVERR
		|-> s_axi_rdata == 32'h0) else $error("refused read carries data");
	chk_rdata_top: assert property (s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h0)
		else $error("read data above register width");
endmodule

// ==== pin_world.sv ====
// Model of the board around the five pins: outside drivers and pull levels.
`timescale 1ns/1ps
module pin_world (
	input  wire logic [4:0] pin_out,
	input  wire logic [4:0] pin_oe,
	input  wire logic [4:0] ext_level,
	output logic      [4:0] pin_in
);
	// A released pin shows the board level, never the last driven value.
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
		end
	end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the pin configuration block.
`timescale 1ns/1ps
module tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, supply_fault_flag, slow_clock_in, wake_request, irq;
	logic power_domain_enable, system_domain_enable, watchdog_trigger;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [4:0]  pin_in, pin_out, pin_oe, sequencer_ctrl, ext_level;
	int          n_errors = 0;
	int          n_tests = 0;
	localparam logic [7:0] REG_IDX [6] = '{pin_cfg_pkg::IDX_PIN01_CFG,
		pin_cfg_pkg::IDX_PIN23_CFG, pin_cfg_pkg::IDX_PIN4_CFG, pin_cfg_pkg::IDX_MODE_BITS,
		pin_cfg_pkg::IDX_OUT_SRC_02, pin_cfg_pkg::IDX_OUT_SRC_34};
	// Six register values in REG_IDX order, then expected pin_out and pin_oe.
	localparam logic [7:0] ROWS [9][8] = '{
		'{8'hFF, 8'hFE, 8'hFF, 8'hF5, 8'h00, 8'h00, 8'h11, 8'h1B},
		'{8'hFF, 8'hFE, 8'h0F, 8'h0A, 8'h00, 8'h00, 8'h0A, 8'h1F},
		'{8'hFF, 8'hFF, 8'h0F, 8'h1F, 8'h19, 8'h13, 8'h15, 8'h1F},
		'{8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h19, 8'h13, 8'h0A, 8'h1F},
		'{8'hFD, 8'hFD, 8'h0D, 8'h0A, 8'h20, 8'h06, 8'h0A, 8'h0A},
		'{8'hFD, 8'hFD, 8'h0D, 8'h0A, 8'h28, 8'h07, 8'h00, 8'h0A},
		'{8'h9F, 8'hFD, 8'h0D, 8'h09, 8'h05, 8'h05, 8'h09, 8'h09},
		'{8'hFF, 8'hD9, 8'h0D, 8'h00, 8'h37, 8'h00, 8'h03, 8'h03},
		'{8'hFF, 8'hFE, 8'h0F, 8'h14, 8'hC0, 8'h08, 8'h10, 8'h1F}};
	// A debounce scale of 1000 shortens filter times, but the longest still outlasts the 20000-cycle run.
	pin_cfg_top #(.DEB_SCALE(1000)) u_pin_cfg_top (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pin_in, .pin_out, .pin_oe, .supply_fault_flag, .slow_clock_in,
		.sequencer_ctrl, .wake_request, .power_domain_enable, .system_domain_enable,
		.watchdog_trigger, .irq);
	pin_world u_pin_world (.pin_out, .pin_oe, .ext_level, .pin_in);
	initial aclk = 1'b0;
	always #12.5 aclk = ~aclk;
	task automatic final_report;
		if (n_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Ready is raised only after valid shows, so the hold of each response is exercised.
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				rsp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
	endtask
	task automatic rdr(input logic [7:0] idx);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		final_report;
	end
	initial begin
		aresetn <= 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
		s_axi_awaddr <= 12'h000;
		s_axi_araddr <= 12'h000;
		s_axi_wdata <= 32'h00000000;
		s_axi_wstrb <= 4'hF;
		supply_fault_flag <= 1'b1;
		slow_clock_in <= 1'b1;
		sequencer_ctrl <= 5'h11;
		ext_level <= 5'h05;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int r = 0; r < 9; r++) begin
			for (int k = 0; k < 6; k++) wr(REG_IDX[k], ROWS[r][k]);
			repeat (8) @(posedge aclk);
			chk({27'h0, pin_out}, {24'h0, ROWS[r][6]});
			chk({27'h0, pin_oe}, {24'h0, ROWS[r][7]});
			for (int k = 0; k < 6; k++) begin
				rdr(REG_IDX[k]);
				chk(rd, {24'h0, ROWS[r][k]});
			end
		end
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
		chk({29'h0, watchdog_trigger, power_domain_enable, system_domain_enable}, 32'h1);
		for (int k = 0; k < 6; k++) begin
			rdr(REG_IDX[k]);
			chk(rd, 32'h0);
		end
		rdr(8'h40);
		chk(rd, 32'h0);
		chk(32'(rsp), 32'(pin_cfg_pkg::AXI_SLVERR));
		wr(8'h40, 8'hFF);
		chk(32'(rsp), 32'(pin_cfg_pkg::AXI_SLVERR));
		wr(pin_cfg_pkg::IDX_IRQ_STATUS, 8'h1F);
		ext_level <= 5'h10;
		repeat (8) @(posedge aclk);
		chk({29'h0, watchdog_trigger, power_domain_enable, system_domain_enable}, 32'h6);
		rdr(pin_cfg_pkg::IDX_IRQ_STATUS);
		chk(rd, 32'h05);
		chk(32'(wake_request), 32'h0);
		wr(pin_cfg_pkg::IDX_IRQ_MASK, 8'h04);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h1);
		wr(pin_cfg_pkg::IDX_IRQ_STATUS, 8'h04);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0);
		rdr(pin_cfg_pkg::IDX_IRQ_STATUS);
		chk(rd, 32'h01);
		wr(pin_cfg_pkg::IDX_WAKE_SENS, 8'h01);
		repeat (4) @(posedge aclk);
		chk(32'(wake_request), 32'h1);
		wr(pin_cfg_pkg::IDX_PIN01_CFG, 8'h08);
		repeat (4) @(posedge aclk);
		chk(32'(wake_request), 32'h0);
		wr(pin_cfg_pkg::IDX_DEBOUNCE, 8'h07);
		wr(pin_cfg_pkg::IDX_MODE_BITS, 8'h01);
		ext_level <= 5'h11;
		repeat (100) @(posedge aclk);
		chk(32'(watchdog_trigger), 32'h1);
		wr(pin_cfg_pkg::IDX_MODE_BITS, 8'h00);
		repeat (8) @(posedge aclk);
		chk(32'(watchdog_trigger), 32'h0);
		// The shortest time is four cycles at this scale: still filtered early, passed later.
		wr(pin_cfg_pkg::IDX_DEBOUNCE, 8'h01);
		wr(pin_cfg_pkg::IDX_MODE_BITS, 8'h01);
		ext_level <= 5'h10;
		repeat (3) @(posedge aclk);
		chk(32'(watchdog_trigger), 32'h0);
		repeat (20) @(posedge aclk);
		chk(32'(watchdog_trigger), 32'h1);
		final_report;
	end
endmodule
bind pin_cfg_top pin_cfg_props u_pin_cfg_props (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.pin_oe, .irq);
